//--- dwu_pkg.sv
// Constants and types for the dual watchdog unit.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package dwu_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] IND_KEY_OFS = 8'h00;
    localparam logic [7:0] IND_PSC_OFS = 8'h04;
    localparam logic [7:0] IND_RLD_OFS = 8'h08;
    localparam logic [7:0] IND_STS_OFS = 8'h0c;
    localparam logic [7:0] WIN_CTRL_OFS = 8'h10;
    localparam logic [7:0] WIN_CFG_OFS = 8'h14;
    localparam logic [7:0] WIN_STS_OFS = 8'h18;

    // ==========================================================
    // Key values
    localparam logic [15:0] KEY_ENABLE = 16'hcccc;
    localparam logic [15:0] KEY_REFRESH = 16'haaaa;
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;

    // ==========================================================
    // Field positions
    localparam int PSC_W = 3;
    localparam int IND_CNT_W = 12;
    localparam int IND_DIV_W = 8;
    localparam int STS_PSC_BIT = 0;
    localparam int STS_RLD_BIT = 1;
    localparam int WIN_CNT_W = 7;
    localparam int WIN_EN_BIT = 7;
    localparam int WIN_WTB_LSB = 7;
    localparam int WIN_EWI_BIT = 9;
    localparam int WIN_FLAG_BIT = 0;
    localparam int WIN_DIV_W = 15;

    // ==========================================================
    // Reset values and thresholds
    localparam logic [2:0] IND_PSC_RST = 3'h0;
    localparam logic [11:0] IND_RLD_RST = 12'hfff;
    localparam logic [11:0] IND_CNT_ZERO = 12'h000;
    localparam logic [6:0] WIN_CNT_RST = 7'h7f;
    localparam logic [6:0] WIN_WIN_RST = 7'h7f;
    localparam logic [6:0] WIN_LIMIT = 7'h40;
    localparam logic [6:0] WIN_FIRE = 7'h3f;

    // ==========================================================
    // Bus request carrier
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dwu_apb_req_t;

endpackage : dwu_pkg

//--- dwu_top.sv
// Dual watchdog unit: independent and window watchdog behind APB.
// Assumes the independent clock arrives as a slow level on IND_CLK_I
// and a system reset clears both reset requests.
//
// Summary of operation
// RL1: Enable key starts independent counter, decrementing per prescaled tick.
// RL2: Independent counter reaching zero requests system reset.
// RL3: Refresh key copies reload value into independent counter.
// RL4: Unlock key allows prescaler and reload value writes.
// RL5: Any other key value locks prescaler and reload again.
// RL6: Refresh key also relocks prescaler and reload.
// RL7: Hardware option starts independent watchdog after reset without key.
// RL8: Debug halt freezes or continues independent counter per external bit.
// RL9: 8-bit prescaler stage, 12-bit counter, 12-bit reload value.
// RL10: Independent watchdog counts on its own clock source.
// RL11: Independent watchdog keeps running in low-power modes.
// RL12: Window counter is 7 bits, free running on prescaled ticks.
// RL13: Window tick is bus clock divided by configured prescaler.
// RL14: Window counter decrementing to 0x3f requests system reset.
// RL15: Refresh while count above window value requests system reset.
// RL16: Prescaler codes divide 4 to 256; change only while update clear.
// RL17: Key register is write-only and reads zero.
// RL18: Software reloads window counter between window value and 0x40.
// RL19: Window watchdog is off after reset, software enable only.
// RL20: Bus writes reach independent counter logic only on its clock edges.
// RL21: Reset requests are registered and held until reset.
`timescale 1ns/1ns
module dwu_top #(
    parameter int WIN_BASE_DIV = 4096
) (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic IND_CLK_I,
    input wire logic HW_WATCHDOG_I,
    input wire logic DBG_HALT_I,
    input wire logic DBG_FREEZE_I,
    output logic IND_RESET_REQ_O,
    output logic WIN_RESET_REQ_O
);

    // ==========================================================
    // Bus slave
    dwu_pkg::dwu_apb_req_t req;
    logic access;
    logic wr;
    logic mapped;
    logic [31:0] rd_mux;

    assign req = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I};
    // Answer in second access cycle so read data comes from a flop
    assign access = req.sel & req.enable & ~PREADY_O;
    assign wr = req.sel & req.enable & PREADY_O & req.write;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == dwu_pkg::IND_KEY_OFS) || (a == dwu_pkg::IND_PSC_OFS)
            || (a == dwu_pkg::IND_RLD_OFS) || (a == dwu_pkg::IND_STS_OFS)
            || (a == dwu_pkg::WIN_CTRL_OFS) || (a == dwu_pkg::WIN_CFG_OFS)
            || (a == dwu_pkg::WIN_STS_OFS);
    endfunction : is_mapped

    assign mapped = is_mapped(req.addr);

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PREADY_O <= 1'b0;
        end else begin
            PREADY_O <= access;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else if (access) begin
            PRDATA_O <= req.write ? 32'h0000_0000 : rd_mux;
            PSLVERR_O <= ~mapped;
        end else begin
            PSLVERR_O <= 1'b0;
        end
    end

    // ==========================================================
    // Independent watchdog: registers
    logic [2:0] psc;
    logic [11:0] reload;
    logic unlocked;
    logic psc_pend;
    logic rld_pend;
    logic key_wr;
    logic [15:0] key_val;

    assign key_wr = wr && (req.addr == dwu_pkg::IND_KEY_OFS);
    assign key_val = req.wdata[15:0];

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            unlocked <= 1'b0;
        end else if (key_wr) begin
            unlocked <= (key_val == dwu_pkg::KEY_UNLOCK); // [RL4] [RL5] [RL6]
        end
    end

    // ==========================================================
    // Independent clock sampling
    logic ind_s1;
    logic ind_s2;
    logic ind_s3;
    logic ind_edge;

    // Every change of counter state waits for this edge [RL10] [RL20]
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ind_s1 <= 1'b0;
            ind_s2 <= 1'b0;
            ind_s3 <= 1'b0;
        end else begin
            ind_s1 <= IND_CLK_I;
            ind_s2 <= ind_s1;
            ind_s3 <= ind_s2;
        end
    end

    assign ind_edge = ind_s2 & ~ind_s3;

    // Write data held here until applied on an independent clock edge
    logic [2:0] psc_shadow;
    logic [11:0] rld_shadow;
    logic start_req;
    logic refresh_req;

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            psc_shadow <= dwu_pkg::IND_PSC_RST;
            psc_pend <= 1'b0;
        end else if (wr && unlocked && !psc_pend
                     && req.addr == dwu_pkg::IND_PSC_OFS) begin
            psc_shadow <= req.wdata[dwu_pkg::PSC_W-1:0]; // [RL4] [RL16]
            psc_pend <= 1'b1;
        end else if (ind_edge) begin
            psc_pend <= 1'b0; // [RL20]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rld_shadow <= dwu_pkg::IND_RLD_RST;
            rld_pend <= 1'b0;
        end else if (wr && unlocked && !rld_pend
                     && req.addr == dwu_pkg::IND_RLD_OFS) begin
            rld_shadow <= req.wdata[dwu_pkg::IND_CNT_W-1:0]; // [RL4]
            rld_pend <= 1'b1;
        end else if (ind_edge) begin
            rld_pend <= 1'b0; // [RL20]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            psc <= dwu_pkg::IND_PSC_RST;
            reload <= dwu_pkg::IND_RLD_RST;
        end else if (ind_edge) begin
            psc <= psc_shadow; // [RL20]
            reload <= rld_shadow;
        end
    end

    // A key arriving on the edge cycle is kept for the next edge
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            start_req <= 1'b0;
            refresh_req <= 1'b0;
        end else begin
            if (key_wr && key_val == dwu_pkg::KEY_ENABLE) begin
                start_req <= 1'b1;
            end else if (ind_edge) begin
                start_req <= 1'b0;
            end
            if (key_wr && key_val == dwu_pkg::KEY_REFRESH) begin
                refresh_req <= 1'b1;
            end else if (ind_edge) begin
                refresh_req <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Hardware watchdog option
    logic strap_done;
    logic running;

    // Strap is caught by a clocked process after reset release
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            running <= 1'b0;
        end else if (!strap_done && HW_WATCHDOG_I) begin
            running <= 1'b1; // [RL7]
        end else if (ind_edge && start_req) begin
            running <= 1'b1; // [RL1]
        end
    end

    // ==========================================================
    // Independent prescaler and counter
    logic [7:0] div_cnt;
    logic [7:0] div_last;
    logic [11:0] ind_cnt;
    logic frozen;
    logic ind_tick;

    // Codes 6 and 7 both give 256
    function automatic logic [7:0] psc_last(input logic [2:0] code);
        logic [8:0] d;
        d = 9'h004 << ((code > 3'h6) ? 3'h6 : code); // [RL16]
        psc_last = 8'(d - 9'h001);
    endfunction : psc_last

    assign div_last = psc_last(psc);
    // No low-power input gates this logic [RL11]
    assign frozen = DBG_HALT_I & DBG_FREEZE_I; // [RL8]
    assign ind_tick = ind_edge && running && !frozen && (div_cnt == div_last);

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_cnt <= 8'h00;
        end else if (ind_edge && running && !frozen) begin
            div_cnt <= (div_cnt == div_last) ? 8'h00 : div_cnt + 8'h01; // [RL9]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ind_cnt <= dwu_pkg::IND_RLD_RST;
        end else if (ind_edge && refresh_req) begin
            ind_cnt <= reload; // [RL3]
        end else if (ind_tick && ind_cnt != dwu_pkg::IND_CNT_ZERO) begin
            ind_cnt <= ind_cnt - 12'h001; // [RL1] [RL9]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            IND_RESET_REQ_O <= 1'b0;
        end else if (running && ind_cnt == dwu_pkg::IND_CNT_ZERO) begin
            IND_RESET_REQ_O <= 1'b1; // [RL2] [RL21]
        end
    end

    // ==========================================================
    // Window watchdog
    logic [6:0] win_cnt;
    logic [6:0] win_val;
    logic [1:0] wtb;
    logic win_en;
    logic ewi_en;
    logic early_flag;
    logic [14:0] wdiv;
    logic [14:0] wdiv_last;
    logic win_tick;
    logic ctrl_wr;

    assign ctrl_wr = wr && (req.addr == dwu_pkg::WIN_CTRL_OFS);
    assign wdiv_last = 15'((WIN_BASE_DIV << wtb) - 1); // [RL13]
    assign win_tick = (wdiv == wdiv_last);

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wdiv <= 15'h0000;
        end else begin
            wdiv <= win_tick ? 15'h0000 : wdiv + 15'h0001; // [RL13]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            win_val <= dwu_pkg::WIN_WIN_RST;
            wtb <= 2'h0;
            ewi_en <= 1'b0;
        end else if (wr && req.addr == dwu_pkg::WIN_CFG_OFS) begin
            win_val <= req.wdata[dwu_pkg::WIN_CNT_W-1:0];
            wtb <= req.wdata[dwu_pkg::WIN_WTB_LSB+:2];
            ewi_en <= req.wdata[dwu_pkg::WIN_EWI_BIT];
        end
    end

    // Enable is set-only so faulty code cannot switch it off
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            win_en <= 1'b0;
        end else if (ctrl_wr && req.wdata[dwu_pkg::WIN_EN_BIT]) begin
            win_en <= 1'b1; // [RL19]
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            win_cnt <= dwu_pkg::WIN_CNT_RST;
        end else if (ctrl_wr) begin
            win_cnt <= req.wdata[dwu_pkg::WIN_CNT_W-1:0];
        end else if (win_tick) begin
            win_cnt <= win_cnt - 7'h01; // [RL12]
        end
    end

    // Set wins over a clear written in the same cycle
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            early_flag <= 1'b0;
        end else if (win_tick && ewi_en && win_cnt == dwu_pkg::WIN_LIMIT) begin
            early_flag <= 1'b1;
        end else if (wr && req.addr == dwu_pkg::WIN_STS_OFS
                     && !req.wdata[dwu_pkg::WIN_FLAG_BIT]) begin
            early_flag <= 1'b0;
        end
    end

    // Reload is safe only between window value and 0x40 [RL18]
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            WIN_RESET_REQ_O <= 1'b0;
        end else if (win_en && ctrl_wr && win_cnt > win_val) begin
            WIN_RESET_REQ_O <= 1'b1; // [RL15] [RL21]
        end else if (win_en && win_tick && win_cnt == dwu_pkg::WIN_LIMIT) begin
            WIN_RESET_REQ_O <= 1'b1; // [RL14] [RL21]
        end
    end

    // ==========================================================
    // Read multiplexer
    always_comb begin
        if (req.addr == dwu_pkg::IND_PSC_OFS) begin
            rd_mux = {29'h0, psc_shadow};
        end else if (req.addr == dwu_pkg::IND_RLD_OFS) begin
            rd_mux = {20'h0, rld_shadow};
        end else if (req.addr == dwu_pkg::IND_STS_OFS) begin
            rd_mux = {30'h0, rld_pend, psc_pend};
        end else if (req.addr == dwu_pkg::WIN_CTRL_OFS) begin
            rd_mux = {24'h0, win_en, win_cnt};
        end else if (req.addr == dwu_pkg::WIN_CFG_OFS) begin
            rd_mux = {22'h0, ewi_en, wtb, win_val};
        end else if (req.addr == dwu_pkg::WIN_STS_OFS) begin
            rd_mux = {31'h0, early_flag};
        end else begin
            rd_mux = 32'h0000_0000; // Key reads zero [RL17]
        end
    end

endmodule : dwu_top

//--- dwu_assertions.sv
// Port checker for the dual watchdog unit.
// Assumes it is bound to dwu_top and sees only its ports.
`timescale 1ns/1ns
module dwu_checker (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic IND_CLK_I,
    input wire logic HW_WATCHDOG_I,
    input wire logic DBG_HALT_I,
    input wire logic DBG_FREEZE_I,
    input wire logic IND_RESET_REQ_O,
    input wire logic WIN_RESET_REQ_O
);
    logic wr_done;
    logic win_on;
    logic ind_on;
    assign wr_done = PREADY_O && PWRITE_I;
    // ==========================================
    // Start tracking
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            win_on <= 1'b0;
            ind_on <= 1'b0;
        end else begin
            win_on <= win_on | (wr_done && PADDR_I == 8'h10 && PWDATA_I[7]);
            ind_on <= ind_on | (wr_done && PADDR_I == 8'h00 && PWDATA_I[15:0] == 16'hcccc);
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    // Access lasts two cycles
    ready_late_a: assert property (PSEL_I && $rose(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside access");
    key_reads_zero_a: assert property (PREADY_O && !PWRITE_I && PADDR_I == 8'h00 |-> PRDATA_O == 32'h0)
        else $error("key register read not zero");
    unmapped_err_a: assert property (PREADY_O && PADDR_I > 8'h18 |-> PSLVERR_O)
        else $error("unmapped access without error");
    mapped_ok_a: assert property (PREADY_O && PADDR_I[1:0] == 2'h0 && PADDR_I <= 8'h18 |-> !PSLVERR_O)
        else $error("mapped access flagged error");
    ind_held_a: assert property (IND_RESET_REQ_O |=> IND_RESET_REQ_O)
        else $error("independent request dropped");
    win_held_a: assert property (WIN_RESET_REQ_O |=> $stable(WIN_RESET_REQ_O))
        else $error("window request dropped");
    win_off_a: assert property (!win_on |-> !WIN_RESET_REQ_O)
        else $error("window request while disabled");
    ind_off_a: assert property (!ind_on && !HW_WATCHDOG_I |-> !IND_RESET_REQ_O)
        else $error("independent request while stopped");
endmodule : dwu_checker
bind dwu_top dwu_checker chk_i (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IND_CLK_I(IND_CLK_I),
    .HW_WATCHDOG_I(HW_WATCHDOG_I), .DBG_HALT_I(DBG_HALT_I), .DBG_FREEZE_I(DBG_FREEZE_I),
    .IND_RESET_REQ_O(IND_RESET_REQ_O), .WIN_RESET_REQ_O(WIN_RESET_REQ_O));

//--- testbench.sv
// Self-checking bench for the dual watchdog unit over APB.
// Assumes dwu_pkg and dwu_top; window base divider shortened to 4.
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ind_clk = 1'b0;
    logic hw = 1'b0;
    logic halt = 1'b0;
    logic frz = 1'b0;
    logic ind_req;
    logic win_req;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int comparisons = 0;
    dwu_top #(.WIN_BASE_DIV(4)) dwu_top_i (.CLOCK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IND_CLK_I(ind_clk),
        .HW_WATCHDOG_I(hw), .DBG_HALT_I(halt), .DBG_FREEZE_I(frz),
        .IND_RESET_REQ_O(ind_req), .WIN_RESET_REQ_O(win_req));
    // ==========================================
    // Clocks
    initial begin
        forever #20 clk = ~clk;
    end
    // Slow watchdog clock, two bus cycles per phase
    initial begin
        forever begin
            repeat (2) @(posedge clk);
            ind_clk <= ~ind_clk;
        end
    end
    // ==========================================
    // Tasks
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic key(input logic [15:0] k);
        apb(1'b1, dwu_pkg::IND_KEY_OFS, {16'h0, k});
    endtask : key
    task automatic pend;
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, dwu_pkg::IND_STS_OFS, 32'h0);
            if (rd[1:0] === 2'h0) break;
        end
        chk({30'h0, rd[1:0]}, 32'h0);
    endtask : pend
    task automatic rst(input logic h);
        rst_b <= 1'b0;
        hw <= h;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask : rst
    // Reload forced small so a timeout comes in tens of cycles
    task automatic short_reload;
        key(dwu_pkg::KEY_UNLOCK);
        apb(1'b1, dwu_pkg::IND_RLD_OFS, 32'h3);
        pend();
    endtask : short_reload
    // ==========================================
    // Sequence
    initial begin
        rst(1'b0);
        apb(1'b0, dwu_pkg::IND_KEY_OFS, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0); chk({31'h0, err}, 32'h1);
        apb(1'b1, dwu_pkg::IND_RLD_OFS, 32'h3);
        apb(1'b0, dwu_pkg::IND_RLD_OFS, 32'h0); chk(rd, 32'hfff);
        key(dwu_pkg::KEY_UNLOCK);
        key(16'h1234);
        apb(1'b1, dwu_pkg::IND_RLD_OFS, 32'h3);
        apb(1'b0, dwu_pkg::IND_RLD_OFS, 32'h0); chk(rd, 32'hfff);
        key(dwu_pkg::KEY_UNLOCK);
        key(dwu_pkg::KEY_REFRESH);
        apb(1'b1, dwu_pkg::IND_RLD_OFS, 32'h3);
        apb(1'b0, dwu_pkg::IND_RLD_OFS, 32'h0); chk(rd, 32'hfff);
        for (int c = 7; c >= 0; c--) begin
            key(dwu_pkg::KEY_UNLOCK);
            apb(1'b1, dwu_pkg::IND_PSC_OFS, 32'(c));
            apb(1'b0, dwu_pkg::IND_PSC_OFS, 32'h0); chk(rd, 32'(c));
            pend();
        end
        for (int h = 0; h < 2; h++) begin
            rst(1'(h));
            short_reload();
            key(dwu_pkg::KEY_REFRESH);
            repeat (300) @(posedge clk); chk({31'h0, ind_req}, 32'(h));
        end
        rst(1'b0);
        short_reload();
        key(dwu_pkg::KEY_ENABLE);
        repeat (6) begin
            repeat (25) @(posedge clk);
            key(dwu_pkg::KEY_REFRESH);
        end
        chk({31'h0, ind_req}, 32'h0);
        halt <= 1'b1;
        frz <= 1'b1;
        repeat (300) @(posedge clk); chk({31'h0, ind_req}, 32'h0);
        frz <= 1'b0;
        repeat (200) @(posedge clk); chk({31'h0, ind_req}, 32'h1);
        halt <= 1'b0;
        // Top code divides by 256, so two ticks take about 2048 cycles
        rst(1'b0);
        key(dwu_pkg::KEY_UNLOCK);
        apb(1'b1, dwu_pkg::IND_PSC_OFS, 32'h7);
        apb(1'b1, dwu_pkg::IND_RLD_OFS, 32'h2);
        pend();
        key(dwu_pkg::KEY_ENABLE);
        key(dwu_pkg::KEY_REFRESH);
        repeat (1900) @(posedge clk); chk({31'h0, ind_req}, 32'h0);
        repeat (400) @(posedge clk); chk({31'h0, ind_req}, 32'h1);
        rst(1'b0);
        repeat (300) @(posedge clk); chk({31'h0, win_req}, 32'h0);
        apb(1'b1, dwu_pkg::WIN_CTRL_OFS, 32'hff);
        repeat (200) @(posedge clk); chk({31'h0, win_req}, 32'h0);
        repeat (80) @(posedge clk); chk({31'h0, win_req}, 32'h1);
        rst(1'b0);
        apb(1'b1, dwu_pkg::WIN_CTRL_OFS, 32'hff);
        apb(1'b1, dwu_pkg::WIN_CFG_OFS, 32'h50);
        repeat (210) @(posedge clk);
        apb(1'b1, dwu_pkg::WIN_CTRL_OFS, 32'hff);
        repeat (150) @(posedge clk); chk({31'h0, win_req}, 32'h0);
        apb(1'b1, dwu_pkg::WIN_CTRL_OFS, 32'hff);
        repeat (4) @(posedge clk); chk({31'h0, win_req}, 32'h1);
        // Slower tick and early flag, window left disabled
        rst(1'b0);
        apb(1'b1, dwu_pkg::WIN_CFG_OFS, 32'h2ff);
        apb(1'b1, dwu_pkg::WIN_CTRL_OFS, 32'h7f);
        apb(1'b0, dwu_pkg::WIN_CFG_OFS, 32'h0); chk(rd, 32'h2ff);
        repeat (476) @(posedge clk);
        apb(1'b0, dwu_pkg::WIN_STS_OFS, 32'h0); chk(rd, 32'h0);
        repeat (60) @(posedge clk);
        apb(1'b0, dwu_pkg::WIN_STS_OFS, 32'h0); chk(rd, 32'h1);
        apb(1'b1, dwu_pkg::WIN_STS_OFS, 32'h0);
        apb(1'b0, dwu_pkg::WIN_STS_OFS, 32'h0); chk(rd, 32'h0);
        chk({31'h0, win_req}, 32'h0);
        tally_and_finish();
    end
    // Whole run needs about five and a half thousand cycles
    initial begin
        #800000;
        num_errors++;
        tally_and_finish();
    end
endmodule : testbench
